// >>> adc_back_end_consts.vh
// register addresses, field positions and reset values of the converter back end
// assumes an 8-bit special function register port with an 8-bit address
`ifndef ADC_BACK_END_CONSTS_VH
`define ADC_BACK_END_CONSTS_VH

// register addresses
`define ADDR_SCAN_CONFIGURATION    8'hA1
`define ADDR_CONTROL_TWO           8'hB3
`define ADDR_CONFIGURATION_ONE     8'hB9
`define ADDR_INPUT_CHANNEL_SELECT  8'hBB
`define ADDR_RESULT_LOW_BYTE       8'hBD
`define ADDR_RESULT_HIGH_BYTE      8'hBE
`define ADDR_GREATER_LIMIT_HIGH    8'hC4
`define ADDR_GREATER_LIMIT_LOW     8'hC3
`define ADDR_LESS_LIMIT_HIGH       8'hC6
`define ADDR_LESS_LIMIT_LOW        8'hC5
`define ADDR_CONTROL_ZERO          8'hE8
`define ADDR_SCAN_START_HIGH       8'h96
`define ADDR_SCAN_START_LOW        8'h97
`define ADDR_SCAN_OUTPUT_COUNT     8'hC7

// control zero fields
`define CZ_WINDOW_FLAG_BIT         3
`define CZ_TEMP_ENABLE_BIT         5
// configuration one fields
`define CF1_REPEAT_LSB             0
`define CF1_SHIFT_LSB              3
`define CF1_PRESERVE_BIT           5
// scan configuration fields
`define SCF_CHANNEL_COUNT_LSB      0
`define SCF_SCAN_ENABLE_BIT        7
// scan start address low fields
`define SAL_ENDIAN_BIT             0

// reset values
`define RESET_BYTE                 8'h00
`define RESET_GREATER_LIMIT        16'hFFFF
`define RESET_LESS_LIMIT           16'h0000
`define RESET_RESULT               16'h0000

// repeat count encoding: 0 single, 1..4 give 4,8,16,32 samples
`define REPEAT_SINGLE              3'h0
`endif

// >>> adc_repeat_counter.v
// counts samples of one accumulation series
// assumes sample_done pulses once per finished conversion on clk
`timescale 1ns/1ps
module adc_repeat_counter
#(
   parameter WIDTH = 6
)
(
   input  wire             clk,
   input  wire             sys_rst,
   input  wire [2:0]       repeat_code,
   input  wire             sample_done,
   input  wire             restart,
   output reg              first_sample,
   output reg              last_sample
);
   reg  [WIDTH-1:0] count;
   reg  [WIDTH-1:0] target;

   // series length minus one: 0, 3, 7, 15, 31
   always @*
   begin
      case (repeat_code)
         3'h1:    target = 6'h03;
         3'h2:    target = 6'h07;
         3'h3:    target = 6'h0F;
         3'h4:    target = 6'h1F;
         default: target = 6'h00;
      endcase
   end

   // flags describe the sample now arriving
   always @*
   begin
      first_sample = (count == {WIDTH{1'b0}});
      last_sample  = (count >= target);
   end

   // position within the series
   always @(posedge clk)
   begin
      if (sys_rst || restart)
         count <= {WIDTH{1'b0}};
      else if (sample_done)
      begin
         if (count >= target)
            count <= {WIDTH{1'b0}};
         else
            count <= count + 1'b1;
      end
   end
endmodule

// >>> adc_window_compare.v
// window detector on the presented result word
// assumes the limits are stable while a compare is taken
`timescale 1ns/1ps
module adc_window_compare
(
   input  wire [15:0]      value,
   input  wire [15:0]      greater_limit,
   input  wire [15:0]      less_limit,
   output reg              hit
);
   reg above;
   reg below;

   // limit order picks inside or outside detection
   always @*
   begin
      above = (value > greater_limit);
      below = (value < less_limit);
      if (greater_limit < less_limit)
         hit = above && below;
      else
         hit = above || below;
   end
endmodule

// >>> adc_accumulate_window_scan_out.v
// converter back end: result registers, accumulator, window detector,
// temperature enable and scan address/count registers
// assumes the analog core gives one code per sample_done pulse on clk
// and firmware reaches the registers over the 8-bit sfr port
`timescale 1ns/1ps
`include "adc_back_end_consts.vh"
module adc_accumulate_window_scan_out
#(
   parameter CODE_WIDTH = 12
)
(
   input  wire                  clk,
   input  wire                  sys_rst,
   input  wire [7:0]            sfr_addr,
   input  wire [7:0]            sfr_wdata,
   input  wire                  sfr_write,
   input  wire                  sfr_read,
   input  wire [CODE_WIDTH-1:0] sample_code,
   input  wire                  sample_done,
   input  wire                  scan_entry,
   output reg  [7:0]            sfr_rdata,
   output reg                   window_flag,
   output reg                   temp_sensor_enable,
   output reg                   scan_enable,
   output reg  [11:0]           shadow_start_address,
   output reg                   shadow_endian,
   output reg  [7:0]            shadow_output_count,
   output reg  [12:0]           shadow_byte_count,
   output reg  [7:0]            shadow_channel,
   output reg  [1:0]            shadow_channel_count
);
   // software visible registers, the accumulator and the compare strobe
   reg  [7:0]  control_zero;
   reg  [7:0]  converter_control_two;
   reg  [7:0]  converter_configuration_one;
   reg  [7:0]  input_channel_select;
   reg  [7:0]  scan_configuration;
   reg  [7:0]  scan_start_address_high;
   reg  [7:0]  scan_start_address_low;
   reg  [7:0]  scan_output_count;
   reg  [15:0] greater_limit;
   reg  [15:0] less_limit;
   reg  [15:0] accumulator;
   reg  [15:0] result;
   reg         compare_pending;

   wire [2:0]  repeat_count_field;
   wire [1:0]  shift_justify_field;
   wire        preserve_accumulator_control;
   wire        first_sample;
   wire        last_sample;
   wire        window_hit;
   reg  [15:0] next_sum;
   reg  [15:0] presented;
   reg         clear_flag;

   assign repeat_count_field =
      converter_configuration_one[`CF1_REPEAT_LSB+2:`CF1_REPEAT_LSB];
   assign shift_justify_field =
      converter_configuration_one[`CF1_SHIFT_LSB+1:`CF1_SHIFT_LSB];
   assign preserve_accumulator_control =
      converter_configuration_one[`CF1_PRESERVE_BIT];

   // series position; restarted when firmware touches the repeat setting
   // a rewrite mid-series starts afresh and drops the partial sum unless it sets the preserve bit
   adc_repeat_counter #(.WIDTH(6)) u_repeat
   (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .repeat_code  (repeat_count_field),
      .sample_done  (sample_done),
      .restart      (sfr_write &&
                     sfr_addr == `ADDR_CONFIGURATION_ONE),
      .first_sample (first_sample),
      .last_sample  (last_sample)
   );

   // window compares the value software would read
   // limits and result are compared as unsigned 16-bit words
   adc_window_compare u_window
   (
      .value         (result),
      .greater_limit (greater_limit),
      .less_limit    (less_limit),
      .hit           (window_hit)
   );

   // accumulator input for the arriving sample
   always @*
   begin
      if (first_sample && !preserve_accumulator_control)
         next_sum = {{(16-CODE_WIDTH){1'b0}}, sample_code};
      else
         next_sum = accumulator + {{(16-CODE_WIDTH){1'b0}}, sample_code};
   end

   // right shift of the finished sum
   always @*
   begin
      presented = next_sum >> shift_justify_field;
   end

   // accumulator, result bytes and their software writes
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         accumulator     <= `RESET_RESULT;
         result          <= `RESET_RESULT;
         compare_pending <= 1'b0;
      end
      else
      begin
         compare_pending <= 1'b0;
         if (sample_done)
         begin
            accumulator <= next_sum;
            // present only at the end of a series
            if (last_sample)
            begin
               // unused upper bits arrive as zeros
               result          <= presented;
               compare_pending <= 1'b1;
            end
         end
         else if (sfr_write && sfr_addr == `ADDR_RESULT_LOW_BYTE)
         begin
            // preset low byte of the sum
            accumulator[7:0] <= sfr_wdata;
            result[7:0]      <= sfr_wdata;
         end
         else if (sfr_write && sfr_addr == `ADDR_RESULT_HIGH_BYTE)
         begin
            // preset high byte of the sum
            accumulator[15:8] <= sfr_wdata;
            result[15:8]      <= sfr_wdata;
         end
      end
   end

   // software clear of the window flag, written as a zero
   always @*
   begin
      clear_flag = sfr_write && sfr_addr == `ADDR_CONTROL_ZERO &&
                   !sfr_wdata[`CZ_WINDOW_FLAG_BIT];
   end

   // sticky flag, a new hit wins over a same-cycle clear
   // a clear that meets a hit is dropped, so no event is lost
   always @(posedge clk)
   begin
      if (sys_rst)
         window_flag <= 1'b0;
      // set on a limit match; in the comparator
      else if (compare_pending && window_hit)
         window_flag <= 1'b1;
      else if (clear_flag)
         window_flag <= 1'b0;
   end

   // plain control and limit registers
   // limit bytes land one at a time; compares see the pair as it stands
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         control_zero                <= `RESET_BYTE;
         converter_control_two       <= `RESET_BYTE;
         converter_configuration_one <= `RESET_BYTE;
         input_channel_select        <= `RESET_BYTE;
         scan_configuration          <= `RESET_BYTE;
         scan_start_address_high     <= `RESET_BYTE;
         scan_start_address_low      <= `RESET_BYTE;
         scan_output_count           <= `RESET_BYTE;
         greater_limit               <= `RESET_GREATER_LIMIT;
         less_limit                  <= `RESET_LESS_LIMIT;
      end
      else if (sfr_write)
      begin
         case (sfr_addr)
            `ADDR_CONTROL_ZERO:         control_zero <= sfr_wdata;
            `ADDR_CONTROL_TWO:          converter_control_two <= sfr_wdata;
            `ADDR_CONFIGURATION_ONE:
               converter_configuration_one <= sfr_wdata;
            `ADDR_INPUT_CHANNEL_SELECT: input_channel_select <= sfr_wdata;
            `ADDR_SCAN_CONFIGURATION:   scan_configuration <= sfr_wdata;
            `ADDR_SCAN_START_HIGH:
               scan_start_address_high <= {4'h0, sfr_wdata[3:0]};
            `ADDR_SCAN_START_LOW:       scan_start_address_low <= sfr_wdata;
            `ADDR_SCAN_OUTPUT_COUNT:    scan_output_count <= sfr_wdata;
            `ADDR_GREATER_LIMIT_HIGH:   greater_limit[15:8] <= sfr_wdata;
            `ADDR_GREATER_LIMIT_LOW:    greater_limit[7:0] <= sfr_wdata;
            `ADDR_LESS_LIMIT_HIGH:      less_limit[15:8] <= sfr_wdata;
            `ADDR_LESS_LIMIT_LOW:       less_limit[7:0] <= sfr_wdata;
            default:                    control_zero <= control_zero;
         endcase
      end
   end

   // pinned-out control levels, registered for clean outputs
   // the extra flop costs a cycle of latency but keeps decode off pins
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         temp_sensor_enable <= 1'b0;
         scan_enable        <= 1'b0;
      end
      else
      begin
         // sensor power follows its control bit
         temp_sensor_enable <= control_zero[`CZ_TEMP_ENABLE_BIT];
         scan_enable        <= scan_configuration[`SCF_SCAN_ENABLE_BIT];
      end
   end

   // scan shadows; the live registers stay free for the next scan
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         shadow_start_address <= 12'h000;
         shadow_endian        <= 1'b0;
         shadow_output_count  <= 8'h00;
         shadow_byte_count    <= 13'h0000;
         shadow_channel       <= 8'h00;
         shadow_channel_count <= 2'h0;
      end
      // copy on scan entry; later writes wait for next entry
      else if (scan_entry)
      begin
         // bit 0 forced low, bits 11:1 from the registers
         shadow_start_address <= {scan_start_address_high[3:0],
                                  scan_start_address_low[7:1], 1'b0};
         shadow_endian        <= scan_start_address_low[`SAL_ENDIAN_BIT];
         shadow_output_count  <= scan_output_count;
         // two bytes per word, (count+1)*2
         // 13 bits hold the largest count, 256 words of two bytes
         shadow_byte_count    <= {4'h0, scan_output_count, 1'b0} +
                                 13'h0002;
         shadow_channel       <= input_channel_select;
         shadow_channel_count <=
            scan_configuration[`SCF_CHANNEL_COUNT_LSB+1:
                               `SCF_CHANNEL_COUNT_LSB];
      end
   end

   // read data, registered; unmapped addresses read zero
   always @(posedge clk)
   begin
      if (sys_rst)
         sfr_rdata <= 8'h00;
      else if (sfr_read)
      begin
         case (sfr_addr)
            `ADDR_CONTROL_ZERO:
               sfr_rdata <= {control_zero[7:4], window_flag,
                             control_zero[2:0]};
            `ADDR_CONTROL_TWO:          sfr_rdata <= converter_control_two;
            `ADDR_CONFIGURATION_ONE:
               sfr_rdata <= converter_configuration_one;
            `ADDR_INPUT_CHANNEL_SELECT: sfr_rdata <= input_channel_select;
            `ADDR_SCAN_CONFIGURATION:   sfr_rdata <= scan_configuration;
            `ADDR_SCAN_START_HIGH:      sfr_rdata <= scan_start_address_high;
            `ADDR_SCAN_START_LOW:       sfr_rdata <= scan_start_address_low;
            `ADDR_SCAN_OUTPUT_COUNT:    sfr_rdata <= scan_output_count;
            // result already shifted, vacated bits are zero
            `ADDR_RESULT_LOW_BYTE:      sfr_rdata <= result[7:0];
            `ADDR_RESULT_HIGH_BYTE:     sfr_rdata <= result[15:8];
            `ADDR_GREATER_LIMIT_HIGH:   sfr_rdata <= greater_limit[15:8];
            `ADDR_GREATER_LIMIT_LOW:    sfr_rdata <= greater_limit[7:0];
            `ADDR_LESS_LIMIT_HIGH:      sfr_rdata <= less_limit[15:8];
            `ADDR_LESS_LIMIT_LOW:       sfr_rdata <= less_limit[7:0];
            default:                    sfr_rdata <= 8'h00;
         endcase
      end
   end
endmodule

// >>> adc_accumulate_window_scan_out_props.sv
// checker on the top ports of the converter back end
// assumes one clock domain with a synchronous active high reset
`timescale 1ns/1ps
`include "adc_back_end_consts.vh"
module adc_accumulate_window_scan_out_props
(
   input wire        clk,
   input wire        sys_rst,
   input wire [7:0]  sfr_addr,
   input wire [7:0]  sfr_wdata,
   input wire        sfr_write,
   input wire        sample_done,
   input wire        scan_entry,
   input wire        window_flag,
   input wire        temp_sensor_enable,
   input wire        scan_enable,
   input wire [11:0] shadow_start_address,
   input wire [7:0]  shadow_output_count,
   input wire [12:0] shadow_byte_count
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // control zero write, and the flag clear it may carry
   sequence s_cz_write;
      sfr_write && sfr_addr == `ADDR_CONTROL_ZERO;
   endsequence
   wire flag_clr = sfr_write && sfr_addr == `ADDR_CONTROL_ZERO &&
                   !sfr_wdata[`CZ_WINDOW_FLAG_BIT];

   a_flag_sticky: assert property (
      window_flag && !flag_clr |=> window_flag)
      else $error("window flag dropped without a clear");
   a_flag_cause: assert property (
      $rose(window_flag) |-> $past(sample_done, 2) || $past(sfr_write)
         || $past(sfr_write, 2))
      else $error("window flag rose with no result update");
   // a set one edge after a sample beats the clear
   a_flag_clear: assert property (
      flag_clr && !$past(sample_done) && !$past(sfr_write) |=> !window_flag)
      else $error("window flag survived a clear");
   // register then output flop: the level follows two edges after the write
   a_temp_copy: assert property (
      s_cz_write |=> ##1 (temp_sensor_enable == $past(sfr_wdata[5], 2)))
      else $error("temperature enable not taken from control zero");
   a_scan_copy: assert property (
      sfr_write && sfr_addr == `ADDR_SCAN_CONFIGURATION
         |=> ##1 (scan_enable == $past(sfr_wdata[7], 2)))
      else $error("scan enable not taken from scan configuration");
   a_addr_even: assert property (
      shadow_start_address[0] == 1'b0)
      else $error("shadow start address is odd");
   a_byte_count: assert property (
      scan_entry |=> shadow_byte_count ==
         ({5'h00, shadow_output_count} + 13'h0001) * 13'h0002)
      else $error("byte count is not twice the word count");
   a_shadow_hold: assert property (
      !scan_entry |=> $stable(shadow_start_address)
         && $stable(shadow_byte_count))
      else $error("shadow changed without a scan entry");
endmodule

// >>> sfr_firmware_model.sv
// firmware side of the register port: single byte writes and reads
// assumes the block answers a read on the edge after the strobe
`timescale 1ns/1ps
`include "adc_back_end_consts.vh"
module sfr_firmware_model
(
   input  wire       clk,
   input  wire [7:0] sfr_rdata,
   output reg  [7:0] sfr_addr,
   output reg  [7:0] sfr_wdata,
   output reg        sfr_write,
   output reg        sfr_read
);
   // idle port at time zero
   initial
   begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_write = 1'b0;
      sfr_read = 1'b0;
   end

   // one cycle write strobe, launched on the falling edge
   task wr(input logic [7:0] a, input logic [7:0] d);
   begin
      if (a == `ADDR_CONFIGURATION_ONE && d[`CF1_PRESERVE_BIT])
         d[2:0] = `REPEAT_SINGLE;
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_write = 1'b1;
      @(negedge clk);
      sfr_write = 1'b0;
      sfr_wdata = ~d; // stale data must not look valid
   end
   endtask

   // one cycle read strobe; data taken a cycle later
   task rd(input logic [7:0] a, output logic [7:0] d);
   begin
      @(negedge clk);
      sfr_addr = a;
      sfr_read = 1'b1;
      @(negedge clk);
      sfr_read = 1'b0;
      d = sfr_rdata;
   end
   endtask
endmodule

// >>> adc_accumulate_window_scan_out_tb.sv
// self-checking bench for the converter back end
// assumes the firmware model drives the register port
`timescale 1ns/1ps
`include "adc_back_end_consts.vh"
module adc_accumulate_window_scan_out_tb;
   logic        clk;
   logic        sys_rst;
   logic [11:0] sample_code;
   logic        sample_done;
   logic        scan_entry;
   wire  [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
   wire         sfr_write, sfr_read, window_flag, temp_sensor_enable;
   wire         scan_enable, shadow_endian;
   wire  [11:0] shadow_start_address;
   wire  [7:0]  shadow_output_count, shadow_channel;
   wire  [12:0] shadow_byte_count;
   wire  [1:0]  shadow_channel_count;
   int          miscompares, check_count, cycles, acc, disp, c;
   logic [7:0]  rb;
   logic [15:0] rv [8] = '{16'hbd00, 16'hbe00, 16'hc3ff, 16'hc4ff,
                           16'hc500, 16'hc600, 16'hb900, 16'h0000};
   logic [47:0] wt [5] = '{48'h0100_0200_0180, 48'h0100_0200_0200,
      48'h0200_0100_0150, 48'h0200_0100_0201, 48'h0200_0100_00ff};

   adc_accumulate_window_scan_out dut_u (.clk, .sys_rst, .sfr_addr,
      .sfr_wdata, .sfr_write, .sfr_read, .sample_code, .sample_done,
      .scan_entry, .sfr_rdata, .window_flag, .temp_sensor_enable,
      .scan_enable, .shadow_start_address, .shadow_endian,
      .shadow_output_count, .shadow_byte_count, .shadow_channel,
      .shadow_channel_count);
   sfr_firmware_model fw_u (.clk, .sfr_rdata, .sfr_addr, .sfr_wdata,
      .sfr_write, .sfr_read);

   // clock, and a cycle ceiling so a hang ends in the report
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         miscompares++;
         close_out;
      end
   end

   task close_out;
   begin
      if (miscompares == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   task chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
   begin
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   end
   endtask

   task chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
   begin
      chk_out(nm, {8'h00, e}, {8'h00, g});
   end
   endtask

   // both result bytes against the model's displayed value
   task chk_res;
   begin
      fw_u.rd(`ADDR_RESULT_LOW_BYTE, rb);
      chk_reg("result_low_byte", disp[7:0], rb);
      fw_u.rd(`ADDR_RESULT_HIGH_BYTE, rb);
      chk_reg("result_high_byte", disp[15:8], rb);
   end
   endtask

   // one finished conversion; code is only meaningful with its strobe
   task smp(input int v);
   begin
      @(negedge clk);
      sample_code = v[11:0];
      sample_done = 1'b1;
      @(negedge clk);
      sample_done = 1'b0;
      sample_code = ~sample_code;
   end
   endtask

   // one series; 32 samples stay under 16 bits by halving the range
   task series(input int rpt, input int sh);
      int n;
   begin
      fw_u.wr(`ADDR_CONFIGURATION_ONE, 8'((sh << 3) | rpt));
      n = (rpt == 0) ? 1 : (2 << rpt);
      acc = 0;
      for (int i = 0; i < n; i++)
      begin
         if (i == n - 1 && n > 1)
            chk_res;
         c = $urandom % ((n == 32) ? 2048 : 4096);
         smp(c);
         acc += c;
      end
      disp = acc >> sh;
      chk_res;
   end
   endtask

   task go_scan;
   begin
      @(negedge clk);
      scan_entry = 1'b1;
      @(negedge clk);
      scan_entry = 1'b0;
   end
   endtask

   function logic win(int v, int g, int l);
      if (g < l)
         return v > g && v < l;
      return v > g || v < l;
   endfunction

   // main sequence
   initial
   begin
      sys_rst = 1'b1;
      sample_code = 12'h000;
      sample_done = 1'b0;
      scan_entry = 1'b0;
      c = $urandom(32'hee24);
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      foreach (rv[i])
      begin
         fw_u.rd(rv[i][15:8], rb);
         chk_reg("reset value", rv[i][7:0], rb);
      end
      for (int r = 0; r < 5; r++)
         series(r, (r + 3) % 4);
      fw_u.wr(`ADDR_CONFIGURATION_ONE, 8'h24);
      fw_u.wr(`ADDR_RESULT_HIGH_BYTE, 8'h12);
      fw_u.wr(`ADDR_RESULT_LOW_BYTE, 8'h34);
      acc = 16'h1234;
      disp = acc;
      chk_res;
      repeat (3)
      begin
         c = $urandom % 4096;
         smp(c);
         acc += c;
         disp = acc;
         chk_res;
      end
      fw_u.wr(`ADDR_CONFIGURATION_ONE, 8'h00);
      fw_u.wr(`ADDR_CONTROL_ZERO, 8'h20);
      // the pin level is one flop behind the register
      @(negedge clk);
      chk_out("temp_sensor_enable", 16'h0001, temp_sensor_enable);
      foreach (wt[i])
      begin
         fw_u.wr(`ADDR_GREATER_LIMIT_HIGH, wt[i][47:40]);
         fw_u.wr(`ADDR_GREATER_LIMIT_LOW, wt[i][39:32]);
         fw_u.wr(`ADDR_LESS_LIMIT_HIGH, wt[i][31:24]);
         fw_u.wr(`ADDR_LESS_LIMIT_LOW, wt[i][23:16]);
         fw_u.wr(`ADDR_CONTROL_ZERO, 8'h00);
         smp(wt[i][15:0]);
         disp = wt[i][15:0];
         chk_res;
         chk_out("window_flag", win(disp, wt[i][47:32], wt[i][31:16]),
            window_flag);
      end
      chk_out("temp_sensor_enable", 16'h0000, temp_sensor_enable);
      fw_u.wr(`ADDR_SCAN_START_HIGH, 8'hf5);
      fw_u.rd(`ADDR_SCAN_START_HIGH, rb);
      chk_reg("start_address_high_field", 8'h05, rb);
      fw_u.wr(`ADDR_SCAN_START_LOW, 8'h37);
      c = $urandom % 256;
      fw_u.wr(`ADDR_SCAN_OUTPUT_COUNT, 8'(c));
      fw_u.wr(`ADDR_INPUT_CHANNEL_SELECT, 8'h1a);
      fw_u.wr(`ADDR_SCAN_CONFIGURATION, 8'h83);
      go_scan;
      chk_out("shadow_start_address", 16'h0536, shadow_start_address);
      chk_out("shadow_endian", 16'h0001, shadow_endian);
      chk_out("shadow_byte_count", 16'((c + 1) * 2), shadow_byte_count);
      chk_out("shadow_channel", 16'h001a, shadow_channel);
      chk_out("shadow_output_count", 16'(c), shadow_output_count);
      chk_out("shadow_channel_count", 16'h0003, shadow_channel_count);
      chk_out("scan_enable", 16'h0001, scan_enable);
      fw_u.wr(`ADDR_SCAN_START_HIGH, 8'h0a);
      fw_u.wr(`ADDR_SCAN_OUTPUT_COUNT, 8'hff);
      chk_out("shadow_start_address", 16'h0536, shadow_start_address);
      go_scan;
      chk_out("shadow_start_address", 16'h0a36, shadow_start_address);
      chk_out("shadow_byte_count", 16'h0200, shadow_byte_count);
      chk_out("shadow_output_count", 16'h00ff, shadow_output_count);
      close_out;
   end
endmodule

bind adc_accumulate_window_scan_out adc_accumulate_window_scan_out_props
   chk_u (.clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_write, .sample_done,
   .scan_entry, .window_flag, .temp_sensor_enable, .scan_enable,
   .shadow_start_address, .shadow_output_count, .shadow_byte_count);
